// >>> rtl/fcp_defines.vh
// Register offsets, field positions, reset values and timing counts for the flash clock/protect block.
`ifndef FCP_DEFINES_VH
`define FCP_DEFINES_VH

`define FCP_KEY_ADDR 8'hf5
`define FCP_DIV_ADDR 8'hf9
`define FCP_PROT_ADDR 8'hfa
`define FCP_EVT_ADDR 8'hfb

`define FCP_KEY_FIRST 8'hb6
`define FCP_KEY_SECOND 8'h49

`define FCP_DIV_RESET 8'h01
`define FCP_PROT_RESET 8'hff
`define FCP_PROT_ALL 8'hff
`define FCP_EVT_RESET 8'h00

`define FCP_BIT_COMPLETION_IRQ_ENABLE 7
`define FCP_BIT_ERROR_IRQ_ENABLE 6
`define FCP_BIT_DONE 5
`define FCP_BIT_WRITE_VIOLATION_FLAG 3
`define FCP_BIT_TMO 2
`define FCP_BIT_PAGE_ERASE_VIOLATION_FLAG 1
`define FCP_BIT_BULK_ERASE_VIOLATION_FLAG 0

`define FCP_BLOCK_SHIFT 14
`define FCP_ROW_TIMEOUT_CLKS 12'h980

`endif

// >>> rtl/fcp_flash_clock_protect.v
// Flash controller clock divider, block protection mask and event/interrupt flags.
`timescale 1ns/10ps
`default_nettype none
`include "fcp_defines.vh"

module fcp_flash_clock_protect (
    // Clock and reset.
    input wire core_clk,
    input wire reset_n,
    // CPU I/O register port, same clock domain.
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_addr,
    input wire [7:0] io_wdata,
    output wire [7:0] io_rdata,
    output wire io_sel,
    // Requests from the program/erase sequencer.
    input wire byte_write_req,
    input wire [16:0] byte_write_offset,
    input wire page_erase_req,
    input wire [16:0] page_erase_offset,
    input wire info_page_sel,
    input wire mass_erase_req,
    input wire row_program_start,
    input wire op_success,
    // Grants and status back to the sequencer.
    output wire byte_write_grant,
    output wire page_erase_grant,
    output wire mass_erase_grant,
    output wire row_program_enable,
    output wire row_program_abort,
    output wire flash_clk_tick,
    output wire unlocked,
    // Interrupt request to the system interrupt controller.
    output wire flash_irq
);

    localparam ST_IDLE = 2'b00;
    localparam ST_KEY1 = 2'b01;
    localparam ST_OPEN = 2'b10;

    reg [1:0] key_state_q;
    reg [1:0] key_state_d;
    reg [7:0] div_q;
    reg [7:0] prot_q;
    reg [7:0] div_cnt_q;
    reg [7:0] div_cnt_d;
    reg tick_q;
    reg tick_d;
    reg [11:0] rp_cnt_q;
    reg rp_en_q;
    reg rp_abort_q;
    reg wr_grant_q;
    reg pg_grant_q;
    reg mass_grant_q;
    reg [7:0] rdata_q;
    reg completion_irq_enable_q;
    reg error_irq_enable_q;
    reg done_q;
    reg done_d;
    reg write_violation_flag_q;
    reg write_violation_flag_d;
    reg tmo_q;
    reg tmo_d;
    reg page_erase_violation_flag_q;
    reg page_erase_violation_flag_d;
    reg bulk_erase_violation_flag_q;
    reg bulk_erase_violation_flag_d;

    wire key_wr;
    wire div_wr;
    wire prot_wr;
    wire evt_wr;
    wire evt_rd;
    wire wr_blocked;
    wire pg_blocked;
    wire mass_blocked;
    wire rp_timeout;
    wire set_done;
    wire any_error;

    // Mask lookup: the info page has no guard bit and is always allowed.
    function blocked_at;
        input [7:0] mask;
        input [16:0] offset;
        input info;
        begin
            blocked_at = !info && mask[offset[16:`FCP_BLOCK_SHIFT]];
        end
    endfunction

    // Address match for one register, qualified by its strobe.
    function addr_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    // Next value of a sticky flag. The set term is ORed in last, so an event
    // that lands in the same cycle as the clearing read is never lost.
    function sticky_next;
        input set;
        input flag;
        input clear;
        begin
            sticky_next = set || (flag && !clear);
        end
    endfunction

    // Image of the event register as the CPU reads it; reserved bit 4 reads zero.
    function [7:0] evt_image;
        input completion_irq_enable;
        input error_irq_enable;
        input done;
        input write_violation_flag;
        input tmo;
        input page_erase_violation_flag;
        input bulk_erase_violation_flag;
        begin
            evt_image = 8'h00;
            evt_image[`FCP_BIT_COMPLETION_IRQ_ENABLE] = completion_irq_enable;
            evt_image[`FCP_BIT_ERROR_IRQ_ENABLE] = error_irq_enable;
            evt_image[`FCP_BIT_DONE] = done;
            evt_image[`FCP_BIT_WRITE_VIOLATION_FLAG] = write_violation_flag;
            evt_image[`FCP_BIT_TMO] = tmo;
            evt_image[`FCP_BIT_PAGE_ERASE_VIOLATION_FLAG] = page_erase_violation_flag;
            evt_image[`FCP_BIT_BULK_ERASE_VIOLATION_FLAG] = bulk_erase_violation_flag;
        end
    endfunction

    assign key_wr = addr_hit(io_wr, io_addr, `FCP_KEY_ADDR);
    assign div_wr = addr_hit(io_wr, io_addr, `FCP_DIV_ADDR);
    assign prot_wr = addr_hit(io_wr, io_addr, `FCP_PROT_ADDR);
    assign evt_wr = addr_hit(io_wr, io_addr, `FCP_EVT_ADDR);
    assign evt_rd = addr_hit(io_rd, io_addr, `FCP_EVT_ADDR);
    assign io_sel = addr_hit(1'b1, io_addr, `FCP_DIV_ADDR) || addr_hit(1'b1, io_addr, `FCP_PROT_ADDR)
        || addr_hit(1'b1, io_addr, `FCP_EVT_ADDR);
    assign unlocked = (key_state_q == ST_OPEN);

    // Outputs come straight from their flip-flops.
    assign io_rdata = rdata_q;
    assign byte_write_grant = wr_grant_q;
    assign page_erase_grant = pg_grant_q;
    assign mass_erase_grant = mass_grant_q;
    assign row_program_enable = rp_en_q;
    assign row_program_abort = rp_abort_q;
    assign flash_clk_tick = tick_q;

    assign wr_blocked = blocked_at(prot_q, byte_write_offset, info_page_sel);
    assign pg_blocked = blocked_at(prot_q, page_erase_offset, info_page_sel);
    assign mass_blocked = |prot_q;
    assign rp_timeout = rp_en_q && tick_q
        && (rp_cnt_q == `FCP_ROW_TIMEOUT_CLKS - 12'h001);
    assign set_done = op_success && !rp_timeout;
    assign any_error = write_violation_flag_q || tmo_q || page_erase_violation_flag_q || bulk_erase_violation_flag_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Unlock key sequence. Only I/O writes advance or break it; reads are ignored.
    always @* begin
        key_state_d = key_state_q;
        if (div_wr || prot_wr) begin
            key_state_d = ST_IDLE;
        end else if (io_wr) begin
            case (key_state_q)
                ST_IDLE: begin
                    key_state_d = (key_wr && io_wdata == `FCP_KEY_FIRST) ? ST_KEY1 : ST_IDLE;
                end
                ST_KEY1: begin
                    if (key_wr && io_wdata == `FCP_KEY_SECOND) begin
                        key_state_d = ST_OPEN;
                    end else if (key_wr && io_wdata == `FCP_KEY_FIRST) begin
                        key_state_d = ST_KEY1;
                    end else begin
                        key_state_d = ST_IDLE;
                    end
                end
                ST_OPEN: begin
                    key_state_d = ST_OPEN;
                end
                default: begin
                    key_state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            key_state_q <= ST_IDLE;
        end else begin
            key_state_q <= key_state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider and protection registers.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= `FCP_DIV_RESET;
            prot_q <= `FCP_PROT_RESET;
        end else begin
            if (div_wr && unlocked) begin
                div_q <= io_wdata;
            end
            if (prot_wr) begin
                prot_q <= unlocked ? io_wdata : `FCP_PROT_ALL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flash controller clock enable. A divider of zero is treated as one so the
    // tick never stops; software is expected to follow the frequency table anyway.
    always @* begin
        if (div_cnt_q + 8'h01 >= div_q) begin
            div_cnt_d = 8'h00;
            tick_d = 1'b1;
        end else begin
            div_cnt_d = div_cnt_q + 8'h01;
            tick_d = 1'b0;
        end
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Row program enable and its timeout, counted in flash controller clocks.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rp_en_q <= 1'b0;
            rp_abort_q <= 1'b0;
            rp_cnt_q <= 12'h000;
        end else begin
            rp_abort_q <= rp_timeout;
            if (rp_timeout) begin
                rp_en_q <= 1'b0;
                rp_cnt_q <= 12'h000;
            end else if (row_program_start && !rp_en_q) begin
                rp_en_q <= 1'b1;
                rp_cnt_q <= 12'h000;
            end else if (rp_en_q && op_success) begin
                rp_en_q <= 1'b0;
            end else if (rp_en_q && tick_q) begin
                rp_cnt_q <= rp_cnt_q + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Grants to the sequencer; a refused request is simply not granted.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_grant_q <= 1'b0;
            pg_grant_q <= 1'b0;
            mass_grant_q <= 1'b0;
        end else begin
            wr_grant_q <= byte_write_req && !wr_blocked;
            pg_grant_q <= page_erase_req && !pg_blocked;
            mass_grant_q <= mass_erase_req && !mass_blocked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event flags. A row program cut short by the timeout in the same cycle as
    // its success strobe is not reported as done, since it did not complete.
    always @* begin
        done_d = sticky_next(set_done, done_q, evt_rd);
        write_violation_flag_d = sticky_next(byte_write_req && wr_blocked, write_violation_flag_q, evt_rd);
        tmo_d = sticky_next(rp_timeout, tmo_q, evt_rd);
        page_erase_violation_flag_d = sticky_next(page_erase_req && pg_blocked, page_erase_violation_flag_q, evt_rd);
        bulk_erase_violation_flag_d = sticky_next(mass_erase_req && mass_blocked, bulk_erase_violation_flag_q, evt_rd);
    end

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            completion_irq_enable_q <= 1'b0;
            error_irq_enable_q <= 1'b0;
            done_q <= 1'b0;
            write_violation_flag_q <= 1'b0;
            tmo_q <= 1'b0;
            page_erase_violation_flag_q <= 1'b0;
            bulk_erase_violation_flag_q <= 1'b0;
        end else begin
            if (evt_wr) begin
                completion_irq_enable_q <= io_wdata[`FCP_BIT_COMPLETION_IRQ_ENABLE];
                error_irq_enable_q <= io_wdata[`FCP_BIT_ERROR_IRQ_ENABLE];
            end
            done_q <= done_d;
            write_violation_flag_q <= write_violation_flag_d;
            tmo_q <= tmo_d;
            page_erase_violation_flag_q <= page_erase_violation_flag_d;
            bulk_erase_violation_flag_q <= bulk_erase_violation_flag_d;
        end
    end

    assign flash_irq = (completion_irq_enable_q && done_q)
        || (error_irq_enable_q && any_error);

    ////////////////////////////////////////////////////////////////////////////////
    // Read data, registered on the read strobe and held until the next read.
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `FCP_DIV_ADDR: rdata_q <= div_q;
                `FCP_PROT_ADDR: rdata_q <= prot_q;
                `FCP_EVT_ADDR: rdata_q <= evt_image(completion_irq_enable_q, error_irq_enable_q, done_q, write_violation_flag_q,
                    tmo_q, page_erase_violation_flag_q, bulk_erase_violation_flag_q);
                default: rdata_q <= 8'h00;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> tb/fcp_flash_clock_protect_properties.sv
// Port-level assertions for the flash clock and protection block.
`timescale 1ns/10ps
`default_nettype none
`include "fcp_defines.vh"
module fcp_props (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port.
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    // Sequencer side.
    input wire logic byte_write_req,
    input wire logic page_erase_req,
    input wire logic mass_erase_req,
    input wire logic info_page_sel,
    input wire logic op_success,
    input wire logic byte_write_grant,
    input wire logic page_erase_grant,
    input wire logic mass_erase_grant,
    input wire logic row_program_enable,
    input wire logic row_program_abort,
    input wire logic unlocked,
    input wire logic flash_irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // Anything that could set a flag, which would mask a read-clear.
    wire logic busy = byte_write_req | page_erase_req | mass_erase_req | op_success
        | row_program_enable | row_program_abort;
    sequence key_first;
        io_wr && io_addr == `FCP_KEY_ADDR && io_wdata == `FCP_KEY_FIRST;
    endsequence
    sequence key_second;
        io_wr && io_addr == `FCP_KEY_ADDR && io_wdata == `FCP_KEY_SECOND;
    endsequence
    sequence guarded_wr;
        io_wr && (io_addr == `FCP_DIV_ADDR || io_addr == `FCP_PROT_ADDR);
    endsequence
    unlock_seq_a: assert property (key_first ##1 !io_wr ##1 key_second |=> unlocked)
        else $error("key pair did not unlock");
    relock_both_a: assert property (guarded_wr |=> !unlocked)
        else $error("still unlocked after guarded write");
    info_page_a: assert property (page_erase_req && info_page_sel |=> page_erase_grant)
        else $error("info page erase refused");
    wr_grant_a: assert property (byte_write_grant |-> $past(byte_write_req))
        else $error("write grant without request");
    pe_grant_a: assert property (page_erase_grant |-> $past(page_erase_req))
        else $error("page grant without request");
    mass_grant_a: assert property (mass_erase_grant |-> $past(mass_erase_req))
        else $error("mass grant without request");
    row_abort_a: assert property (row_program_abort |-> !row_program_enable)
        else $error("row enable kept on abort");
    read_clear_a: assert property (io_rd && io_addr == `FCP_EVT_ADDR && !busy ##1 !busy
        |=> !flash_irq) else $error("irq survived read");
endmodule
`default_nettype wire

// >>> tb/fcp_cpu.sv
// CPU model issuing I/O register writes and reads to the block.
`timescale 1ns/10ps
`default_nettype none
`include "fcp_defines.vh"
module fcp_cpu (
    // Clock.
    input wire logic core_clk,
    // I/O register port.
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    logic [7:0] q;
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
    end
    // Released data is inverted so that nothing can lean on a stale value.
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        begin
            @(posedge core_clk);
            io_wr <= w;
            io_rd <= !w;
            io_addr <= a;
            io_wdata <= d;
            @(posedge core_clk);
            io_wr <= 1'b0;
            io_rd <= 1'b0;
            io_wdata <= ~d;
            #1;
            r = io_rdata;
        end
    endtask
    task unlock;
        begin
            acc(1'b1, `FCP_KEY_ADDR, `FCP_KEY_FIRST, q);
            acc(1'b1, `FCP_KEY_ADDR, `FCP_KEY_SECOND, q);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the flash clock and protection block.
`timescale 1ns/10ps
`default_nettype none
`include "fcp_defines.vh"
module tb;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic byte_write_req = 1'b0, page_erase_req = 1'b0, mass_erase_req = 1'b0;
    logic info_page_sel = 1'b0, op_success = 1'b0, row_program_start = 1'b0, free;
    logic [16:0] off = 17'h00000;
    logic [7:0] d;
    wire logic io_wr, io_rd, byte_write_grant, page_erase_grant, mass_erase_grant, unlocked;
    wire logic row_program_enable, row_program_abort, flash_clk_tick, flash_irq, io_sel;
    wire logic [7:0] io_addr, io_wdata, io_rdata;
    integer n_errors = 0, n_tests = 0, i, cyc = 0, last = 0, prev = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (flash_clk_tick === 1'b1) begin
            prev <= last;
            last <= cyc;
        end
    end
    fcp_flash_clock_protect i_fcp_flash_clock_protect (.core_clk, .reset_n, .io_wr, .io_rd,
        .io_addr, .io_wdata, .io_rdata, .io_sel, .byte_write_req, .byte_write_offset(off),
        .page_erase_req, .page_erase_offset(off), .info_page_sel, .mass_erase_req,
        .row_program_start, .op_success, .byte_write_grant, .page_erase_grant,
        .mass_erase_grant, .row_program_enable, .row_program_abort, .flash_clk_tick,
        .unlocked, .flash_irq);
    fcp_cpu i_fcp_cpu (.core_clk, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata);
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        begin
            n_tests++;
            if (s !== e) begin
                n_errors++;
                $display("unexpected %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task w(input logic [7:0] a, input logic [7:0] v);
        i_fcp_cpu.acc(1'b1, a, v, d);
    endtask
    task r(input logic [7:0] a, input logic [7:0] e);
        begin
            i_fcp_cpu.acc(1'b0, a, 8'h00, d);
            chk("register", d, e);
        end
    endtask
    task req(input integer k, input logic [16:0] o, input logic g);
        begin
            @(posedge core_clk);
            off <= o;
            byte_write_req <= (k == 0);
            page_erase_req <= (k == 1);
            mass_erase_req <= (k == 2);
            @(posedge core_clk);
            byte_write_req <= 1'b0;
            page_erase_req <= 1'b0;
            mass_erase_req <= 1'b0;
            #1;
            chk("grant", {7'h00, k == 0 ? byte_write_grant : k == 1 ? page_erase_grant
                : mass_erase_grant}, {7'h00, g});
        end
    endtask
    task strobe(input logic s);
        begin
            @(posedge core_clk);
            op_success <= !s;
            row_program_start <= s;
            @(posedge core_clk);
            op_success <= 1'b0;
            row_program_start <= 1'b0;
            #1;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        r(`FCP_DIV_ADDR, `FCP_DIV_RESET);
        chk("io sel", {7'h00, io_sel}, 8'h01);
        r(`FCP_PROT_ADDR, `FCP_PROT_RESET);
        r(`FCP_EVT_ADDR, `FCP_EVT_RESET);
        i_fcp_cpu.unlock();
        w(`FCP_PROT_ADDR, 8'h0f);
        r(`FCP_PROT_ADDR, 8'h0f);
        w(`FCP_PROT_ADDR, 8'h00);
        r(`FCP_PROT_ADDR, `FCP_PROT_ALL);
        w(`FCP_KEY_ADDR, `FCP_KEY_FIRST);
        chk("io sel", {7'h00, io_sel}, 8'h00);
        r(`FCP_EVT_ADDR, 8'h00);
        w(`FCP_KEY_ADDR, `FCP_KEY_SECOND);
        chk("unlocked", {7'h00, unlocked}, 8'h01);
        w(`FCP_PROT_ADDR, 8'h5a);
        chk("unlocked", {7'h00, unlocked}, 8'h00);
        w(`FCP_DIV_ADDR, 8'h05);
        r(`FCP_DIV_ADDR, `FCP_DIV_RESET);
        $display("test key and lock finished");
        for (i = 0; i < 8; i++) begin
            free = ((8'h5a >> i) & 8'h01) == 8'h00;
            req(0, 17'(i << 14) | 17'h03fff, free);
            req(1, 17'(i << 14), free);
        end
        r(`FCP_EVT_ADDR, 8'h0a);
        @(posedge core_clk);
        info_page_sel <= 1'b1;
        req(1, 17'h04000, 1'b1);
        @(posedge core_clk);
        info_page_sel <= 1'b0;
        r(`FCP_EVT_ADDR, 8'h00);
        $display("test block guards finished");
        w(`FCP_EVT_ADDR, 8'hc0);
        req(2, 17'h00000, 1'b0);
        chk("irq", {7'h00, flash_irq}, 8'h01);
        r(`FCP_EVT_ADDR, 8'hc1);
        chk("irq", {7'h00, flash_irq}, 8'h00);
        i_fcp_cpu.unlock();
        w(`FCP_PROT_ADDR, 8'h00);
        req(2, 17'h00000, 1'b1);
        w(`FCP_EVT_ADDR, 8'h40);
        strobe(1'b0);
        chk("irq", {7'h00, flash_irq}, 8'h00);
        r(`FCP_EVT_ADDR, 8'h60);
        w(`FCP_EVT_ADDR, 8'h80);
        strobe(1'b0);
        chk("irq", {7'h00, flash_irq}, 8'h01);
        r(`FCP_EVT_ADDR, 8'ha0);
        $display("test events finished");
        i_fcp_cpu.unlock();
        w(`FCP_DIV_ADDR, 8'h05);
        r(`FCP_DIV_ADDR, 8'h05);
        repeat (12) @(posedge core_clk);
        #1;
        chk("tick gap", 8'(last - prev), 8'h05);
        i_fcp_cpu.unlock();
        w(`FCP_DIV_ADDR, 8'h01);
        strobe(1'b1);
        repeat (2400) @(posedge core_clk);
        #1;
        chk("row enable", {7'h00, row_program_enable}, 8'h01);
        for (i = 0; i < 100 && row_program_abort !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("abort", {7'h00, row_program_abort}, 8'h01);
        chk("timeout cycle", 8'(i), 8'(`FCP_ROW_TIMEOUT_CLKS - 12'h960));
        chk("row enable", {7'h00, row_program_enable}, 8'h00);
        r(`FCP_EVT_ADDR, 8'h84);
        strobe(1'b1);
        chk("row enable", {7'h00, row_program_enable}, 8'h01);
        strobe(1'b0);
        chk("row enable", {7'h00, row_program_enable}, 8'h00);
        r(`FCP_EVT_ADDR, 8'ha0);
        $display("test divider and timeout finished");
        final_report();
    end
    // The tests need about 2,600 cycles; this allows several times that.
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
endmodule
bind fcp_flash_clock_protect fcp_props i_fcp_props (.core_clk, .reset_n, .io_wr, .io_rd,
    .io_addr, .io_wdata, .byte_write_req, .page_erase_req, .mass_erase_req, .info_page_sel,
    .op_success, .byte_write_grant, .page_erase_grant, .mass_erase_grant,
    .row_program_enable, .row_program_abort, .unlocked, .flash_irq);
`default_nettype wire
